//--- design/pdm_ctrl.sv
// module: power-down mode controller, top level
// Operation
// - idle_op enters light idle when select bit is zero, deep idle when one
// - select bit cleared plus idle_op gives light idle
// - light idle keeps oscillators, interrupts, timer and sound generator running
// - light idle halts the cpu clock until wake-up
// - registers, ram and pins hold their values in every power-down state
// - light idle ends on reset or any interrupt request
// - deep idle halts cpu; timer and sound run only when on crystal clock
// - both idle states wake on an interrupt request
// - deep idle wakes through the same interrupt sequence as light idle
// - deep idle wake inserts warm-up cycles before the cpu resumes
// - halt_all_op enters stop regardless of the select bit
// - stop halts core; timer and sound run only when on crystal clock
// - stop ends only by hardware reset, never by interrupt
// - leaving stop by reset inserts warm-up cycles before execution
// - interrupt-disable set: wake, continue after idle_op, no service routine
// - interrupt-disable clear: wake and take the requesting vector
`timescale 1ns/100ps
module pdm_ctrl #(
    parameter int unsigned WARM_CYCLES = pdm_pkg::WARM_CYC
) (
    input  wire logic        clk,            // 10 MHz system clock
    input  wire logic        rst_b,          // async hardware reset, active low
    input  wire logic        idle_op,        // cpu executes idle instruction, pulse
    input  wire logic        halt_all_op,    // cpu executes stop instruction, pulse
    input  wire logic [7:0]  system_control_reg, // system control register value
    input  wire logic        irq_req,        // any interrupt request, level
    input  wire logic        irq_disable,    // cpu interrupt-disable flag
    input  wire logic        periph_on_xtal, // timer and sound clocked from crystal
    output logic             cpu_clk_en,     // cpu clock enable
    output logic             osc_fast_en,    // fast rc oscillator run
    output logic             osc_xtal_en,    // crystal oscillator run
    output logic             periph_fast_en, // timer/sound enable on fast clock
    output logic             periph_xtal_en, // timer/sound enable on crystal clock
    output logic             hold_state,     // freeze registers, ram and pins
    output logic             take_vector,    // pulse: fetch interrupt vector
    output logic             resume_next,    // pulse: continue after idle_op
    output logic [2:0]       power_state     // current state code, 0 during reset and the first cycle after release
);
    pdm_pkg::pdm_state_e state_q;
    pdm_pkg::pdm_state_e state_d;
    pdm_pkg::pdm_gates_s gates_d;
    pdm_pkg::pdm_gates_s gates_q;
    pdm_pkg::pdm_wake_s  wake_d;
    pdm_pkg::pdm_wake_s  wake_q;
    logic                irq_s;
    logic                warm_start;
    logic                warm_done;
    logic                boot_q;
    logic                deep_sel;

    // interrupt request comes from other clocks, so filter it
    pdm_sync #(
        .STAGES (pdm_pkg::SYNC_STAGES)
    ) u_irq_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (irq_req),
        .q     (irq_s)
    );

    pdm_warm_cnt #(
        .CYCLES (WARM_CYCLES)
    ) u_warm (
        .clk   (clk),
        .rst_b (rst_b),
        .start (warm_start),
        .done  (warm_done)
    );

    assign deep_sel = system_control_reg[pdm_pkg::SLEEP_SEL_BIT];

    // one-shot marker so the first cycle after reset loads the warm-up counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // warm-up reload: after reset release and on deep idle wake
    assign warm_start = boot_q ||
                        (state_q == pdm_pkg::PDM_DEEP_IDLE && irq_s);

    // next state; stop is only left through rst_b, which is async
    always_comb begin
        state_d = state_q;
        case (state_q)
            pdm_pkg::PDM_RUN: begin
                if (halt_all_op) begin
                    state_d = pdm_pkg::PDM_STOP;
                end else if (idle_op) begin
                    state_d = deep_sel ? pdm_pkg::PDM_DEEP_IDLE
                                       : pdm_pkg::PDM_LIGHT_IDLE;
                end
            end
            pdm_pkg::PDM_LIGHT_IDLE: begin
                if (irq_s) begin
                    state_d = pdm_pkg::PDM_RUN;
                end
            end
            pdm_pkg::PDM_DEEP_IDLE: begin
                if (irq_s) begin
                    state_d = pdm_pkg::PDM_WARM;
                end
            end
            pdm_pkg::PDM_WARM: begin
                if (warm_done) begin
                    state_d = pdm_pkg::PDM_RUN;
                end
            end
            pdm_pkg::PDM_STOP: begin
                state_d = pdm_pkg::PDM_STOP;
            end
            pdm_pkg::PDM_BOOT_WARM: begin
                if (warm_done && !boot_q) begin
                    state_d = pdm_pkg::PDM_RUN;
                end
            end
            default: begin
                state_d = pdm_pkg::PDM_RUN;
            end
        endcase
    end

    // state register; reset always restarts through the warm-up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= pdm_pkg::PDM_BOOT_WARM;
        end else begin
            state_q <= state_d;
        end
    end

    // gate decode from the next state so outputs line up with the state register
    always_comb begin
        gates_d = '0;
        case (state_d)
            pdm_pkg::PDM_RUN: begin
                gates_d = '1;
            end
            pdm_pkg::PDM_LIGHT_IDLE: begin
                gates_d = '1;
                gates_d.cpu_clk_en = 1'b0;
            end
            pdm_pkg::PDM_DEEP_IDLE, pdm_pkg::PDM_STOP: begin
                gates_d.osc_xtal_en    = periph_on_xtal;
                gates_d.periph_xtal_en = periph_on_xtal;
            end
            pdm_pkg::PDM_WARM, pdm_pkg::PDM_BOOT_WARM: begin
                gates_d = '1;
                gates_d.cpu_clk_en = 1'b0;
            end
            default: begin
                gates_d = '1;
            end
        endcase
    end

    // gates held in flops; outputs come straight from them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gates_q <= '0;
        end else begin
            gates_q <= gates_d;
        end
    end

    // wake report: one pulse when the cpu clock returns after an idle
    always_comb begin
        wake_d = '0;
        if (state_d == pdm_pkg::PDM_RUN &&
            (state_q == pdm_pkg::PDM_LIGHT_IDLE || state_q == pdm_pkg::PDM_WARM)) begin
            wake_d.take_vector = !irq_disable;
            wake_d.resume_next = irq_disable;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_q <= '0;
        end else begin
            wake_q <= wake_d;
        end
    end

    // hold request: freeze everything except during normal run and the reset warm-up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_state <= 1'b0;
        end else begin
            hold_state <= (state_d != pdm_pkg::PDM_RUN) &&
                          (state_d != pdm_pkg::PDM_BOOT_WARM);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_state <= 3'h0;
        end else begin
            power_state <= state_d;
        end
    end

    assign cpu_clk_en     = gates_q.cpu_clk_en;
    assign osc_fast_en    = gates_q.osc_fast_en;
    assign osc_xtal_en    = gates_q.osc_xtal_en;
    assign periph_fast_en = gates_q.periph_fast_en;
    assign periph_xtal_en = gates_q.periph_xtal_en;
    assign take_vector    = wake_q.take_vector;
    assign resume_next    = wake_q.resume_next;

    // idle_op with select bit low lands in light idle
    property p_light_entry;
        @(posedge clk) disable iff (!rst_b)
        (state_q == pdm_pkg::PDM_RUN && idle_op && !halt_all_op && !deep_sel)
            |=> (state_q == pdm_pkg::PDM_LIGHT_IDLE) && !cpu_clk_en && osc_fast_en;
    endproperty
    a_light_entry: assert property (p_light_entry) else $error("light idle entry wrong");

    property p_deep_entry;
        @(posedge clk) disable iff (!rst_b)
        (state_q == pdm_pkg::PDM_RUN && idle_op && !halt_all_op && deep_sel)
            |=> state_q == pdm_pkg::PDM_DEEP_IDLE && !periph_fast_en;
    endproperty
    a_deep_entry: assert property (p_deep_entry) else $error("deep idle entry wrong");

    property p_stop_entry;
        @(posedge clk) disable iff (!rst_b)
        (state_q == pdm_pkg::PDM_RUN && halt_all_op) |=> state_q == pdm_pkg::PDM_STOP;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");

    property p_stop_sticky;
        @(posedge clk) disable iff (!rst_b)
        state_q == pdm_pkg::PDM_STOP |=> state_q == pdm_pkg::PDM_STOP && !cpu_clk_en;
    endproperty
    a_stop_sticky: assert property (p_stop_sticky) else $error("stop left without reset");

    property p_light_periph;
        @(posedge clk) disable iff (!rst_b)
        state_q == pdm_pkg::PDM_LIGHT_IDLE |-> periph_fast_en && osc_xtal_en && hold_state;
    endproperty
    a_light_periph: assert property (p_light_periph) else $error("light idle stopped peripherals");

    property p_xtal_follow;
        @(posedge clk) disable iff (!rst_b)
        (state_q == pdm_pkg::PDM_STOP && $stable(periph_on_xtal)) |=> periph_xtal_en == $past(periph_on_xtal);
    endproperty
    a_xtal_follow: assert property (p_xtal_follow) else $error("crystal peripheral gate wrong");

    sequence s_deep_wake;
        state_q == pdm_pkg::PDM_DEEP_IDLE && irq_s;
    endsequence
    sequence s_warm_hold;
        (!cpu_clk_en && state_q == pdm_pkg::PDM_WARM) [*8];
    endsequence
    property p_deep_warm;
        @(posedge clk) disable iff (!rst_b)
        s_deep_wake |=> s_warm_hold;
    endproperty
    a_deep_warm: assert property (p_deep_warm) else $error("deep wake skipped warm-up");

    property p_light_wake;
        @(posedge clk) disable iff (!rst_b)
        (state_q == pdm_pkg::PDM_LIGHT_IDLE && irq_s)
            |=> cpu_clk_en && (take_vector == !$past(irq_disable)) && (resume_next == $past(irq_disable));
    endproperty
    a_light_wake: assert property (p_light_wake) else $error("light wake report wrong");

    // light idle keeps every oscillator and peripheral gate open, only the core stops
    property p_light_osc;
        @(posedge clk) disable iff (!rst_b)
        state_q == pdm_pkg::PDM_LIGHT_IDLE
            |-> osc_fast_en && periph_xtal_en && !cpu_clk_en;
    endproperty
    a_light_osc: assert property (p_light_osc) else $error("light idle gates wrong");

    // deep idle: the fast domain is fully off, whatever the crystal side does
    property p_deep_gates;
        @(posedge clk) disable iff (!rst_b)
        state_q == pdm_pkg::PDM_DEEP_IDLE
            |-> !osc_fast_en && !periph_fast_en && !cpu_clk_en && hold_state;
    endproperty
    a_deep_gates: assert property (p_deep_gates) else $error("deep idle gates wrong");

    // stop: same fast-domain shutdown as deep idle, state frozen
    property p_stop_gates;
        @(posedge clk) disable iff (!rst_b)
        state_q == pdm_pkg::PDM_STOP
            |-> !osc_fast_en && !periph_fast_en && hold_state;
    endproperty
    a_stop_gates: assert property (p_stop_gates) else $error("stop gates wrong");

    // warm-up: oscillators restarted but the core clock stays gated
    property p_warm_gates;
        @(posedge clk) disable iff (!rst_b)
        state_q == pdm_pkg::PDM_WARM
            |-> !cpu_clk_en && osc_fast_en && osc_xtal_en && hold_state;
    endproperty
    a_warm_gates: assert property (p_warm_gates) else $error("warm-up gates wrong");

    // normal run: core clocked and nothing frozen
    property p_run_open;
        @(posedge clk) disable iff (!rst_b)
        state_q == pdm_pkg::PDM_RUN |-> cpu_clk_en && !hold_state;
    endproperty
    a_run_open: assert property (p_run_open) else $error("run state gated");

    // without a synchronised request an idle state is never left
    property p_idle_holds;
        @(posedge clk) disable iff (!rst_b)
        ((state_q == pdm_pkg::PDM_LIGHT_IDLE || state_q == pdm_pkg::PDM_DEEP_IDLE) && !irq_s)
            |=> state_q == $past(state_q) && !cpu_clk_en;
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("idle left without request");

    // deep wake ends the warm-up with the same report as a light wake
    sequence s_warm_exit;
        state_q == pdm_pkg::PDM_WARM && warm_done;
    endsequence
    property p_deep_report;
        @(posedge clk) disable iff (!rst_b)
        s_warm_exit |=> cpu_clk_en && state_q == pdm_pkg::PDM_RUN &&
                        (take_vector == !$past(irq_disable)) && (resume_next == $past(irq_disable));
    endproperty
    a_deep_report: assert property (p_deep_report) else $error("deep wake report wrong");

    // the two wake reports never coincide and last a single cycle
    property p_wake_pulse;
        @(posedge clk) disable iff (!rst_b)
        (take_vector || resume_next)
            |-> !(take_vector && resume_next) ##1 !(take_vector || resume_next);
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake report not one pulse");

    // after any reset the core clock stays gated through the warm-up
    sequence s_boot_begin;
        state_q == pdm_pkg::PDM_BOOT_WARM && boot_q;
    endsequence
    sequence s_boot_hold;
        (state_q == pdm_pkg::PDM_BOOT_WARM && !cpu_clk_en && !hold_state) [*8];
    endsequence
    property p_boot_warm;
        @(posedge clk) disable iff (!rst_b)
        s_boot_begin |=> s_boot_hold;
    endproperty
    a_boot_warm: assert property (p_boot_warm) else $error("reset skipped warm-up");
endmodule // pdm_ctrl

//--- design/pdm_pkg.sv
// package: power-down mode controller types and constants
package pdm_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned WARM_US         = 100;
    localparam int unsigned WARM_CYC        = (WARM_US * (CLK_HZ / 1_000_000) > 0) ?
                                              WARM_US * (CLK_HZ / 1_000_000) : 1;
    localparam int unsigned SYNC_STAGES     = 3;
    localparam int unsigned SLEEP_SEL_BIT   = 2;
    localparam logic [7:0]  SYS_CTRL_RST    = 8'h00;

    // power states, gray along deep idle -> warm -> run and run <-> light idle
    typedef enum logic [2:0] {
        PDM_RUN        = 3'b000,
        PDM_LIGHT_IDLE = 3'b001,
        PDM_DEEP_IDLE  = 3'b011,
        PDM_WARM       = 3'b010,
        PDM_STOP       = 3'b110,
        PDM_BOOT_WARM  = 3'b111
    } pdm_state_e;

    // clock and run enables towards the rest of the chip
    typedef struct packed {
        logic cpu_clk_en;
        logic osc_fast_en;
        logic osc_xtal_en;
        logic periph_fast_en;
        logic periph_xtal_en;
    } pdm_gates_s;

    // wake report towards the cpu
    typedef struct packed {
        logic take_vector;
        logic resume_next;
    } pdm_wake_s;
endpackage

//--- design/pdm_sync.sv
// module: three-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
module pdm_sync #(
    parameter int unsigned STAGES = 3
) (
    input  wire logic clk,   // system clock
    input  wire logic rst_b, // async reset, active low
    input  wire logic d,     // async level in
    output logic      q      // filtered level out
);
    logic [STAGES-1:0] s_q;

    // shift chain; only the last two stages are compared
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= {s_q[STAGES-2:0], d};
        end
    end

    // level changes only once the second and third stages agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= 1'b0;
        end else if (s_q[STAGES-1] == s_q[STAGES-2]) begin
            q <= s_q[STAGES-1];
        end
    end
endmodule // pdm_sync

//--- design/pdm_warm_cnt.sv
// module: warm-up down counter
`timescale 1ns/100ps
module pdm_warm_cnt #(
    parameter int unsigned CYCLES = 1000
) (
    input  wire logic clk,   // system clock
    input  wire logic rst_b, // async reset, active low
    input  wire logic start, // load pulse
    output logic      done   // level: count expired
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);
    logic [W-1:0] cnt_q;

    // reload on start, count down to zero otherwise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= LOAD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign done = (cnt_q == '0) && !start;
endmodule // pdm_warm_cnt

//--- sim/pdm_cpu_model.sv
// file: behavioural cpu core that issues power-down instructions
`timescale 1ns/100ps
module pdm_cpu_model (
    input  wire logic clk,                // system clock
    input  wire logic cpu_clk_en,         // core clock enable from controller
    input  wire logic take_vector,        // wake into service routine
    input  wire logic resume_next,        // wake past the idle instruction
    output logic      idle_op     = 1'b0, // idle instruction pulse
    output logic      halt_all_op = 1'b0, // stop instruction pulse
    output logic      irq_disable = 1'b0  // interrupt-disable flag
);
    int n_vec = 0;
    int n_res = 0;

    // count wake reports, sampled on the edge like the real core would
    always @(posedge clk) begin
        if (take_vector === 1'b1) n_vec++;
        if (resume_next === 1'b1) n_res++;
    end

    // a halted core fetches nothing, so an instruction waits for its clock
    task automatic exec_op(input logic idle, input logic halt);
        for (int i = 0; i < 500 && cpu_clk_en !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        idle_op     = idle;
        halt_all_op = halt;
        @(posedge clk);
        #1;
        idle_op     = 1'b0;
        halt_all_op = 1'b0;
    endtask
endmodule // pdm_cpu_model

//--- sim/test_power_down_mode_control.sv
// file: self-checking bench for the power-down mode controller
`timescale 1ns/100ps
module test_power_down_mode_control;
    localparam int W = 10; // shortened warm-up keeps the run brief
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] sys_reg = 8'h00;
    logic       irq_req = 1'b0;
    logic       on_xtal = 1'b0;
    logic       idle_op, halt_all_op, irq_disable, take_vector, resume_next;
    logic       cpu_clk_en, osc_fast_en, osc_xtal_en, periph_fast_en, periph_xtal_en, hold_state;
    logic [2:0] power_state;
    int         fails = 0;
    int         n_tests = 0;

    always #50 clk = ~clk;

    pdm_ctrl #(.WARM_CYCLES(W)) u_dut (
        .clk(clk), .rst_b(rst_b), .idle_op(idle_op), .halt_all_op(halt_all_op),
        .system_control_reg(sys_reg), .irq_req(irq_req), .irq_disable(irq_disable),
        .periph_on_xtal(on_xtal), .cpu_clk_en(cpu_clk_en), .osc_fast_en(osc_fast_en),
        .osc_xtal_en(osc_xtal_en), .periph_fast_en(periph_fast_en), .periph_xtal_en(periph_xtal_en),
        .hold_state(hold_state), .take_vector(take_vector), .resume_next(resume_next),
        .power_state(power_state));

    pdm_cpu_model u_cpu (
        .clk(clk), .cpu_clk_en(cpu_clk_en), .take_vector(take_vector), .resume_next(resume_next),
        .idle_op(idle_op), .halt_all_op(halt_all_op), .irq_disable(irq_disable));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // clocks gated while the warm-up runs; counted edge by edge
    task automatic count_gated(output int n);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic t_reset();
        int n;
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("reset state", 8'h00, {4'h0, cpu_clk_en, power_state});
        rst_b = 1'b1;
        count_gated(n);
        chk("boot warm length", 8'h01, 8'(n >= W && n <= W + 4));
        chk("boot run state", 8'h00, {5'h0, power_state});
    endtask

    task automatic t_light();
        int n;
        int v;
        sys_reg = 8'h00;
        u_cpu.irq_disable = 1'b0;
        u_cpu.exec_op(1'b1, 1'b0);
        chk("light state", 8'h01, {5'h0, power_state});
        chk("light gates", 8'h2f, {2'h0, periph_xtal_en, cpu_clk_en, osc_fast_en, osc_xtal_en,
            periph_fast_en, hold_state});
        repeat (20) @(posedge clk);
        #1;
        chk("light stays", 8'h01, {4'h0, cpu_clk_en, power_state});
        v = u_cpu.n_vec;
        irq_req = 1'b1;
        count_gated(n);
        chk("light wake time", 8'h01, 8'(n <= 7));
        repeat (2) @(posedge clk);
        #1;
        chk("light vector", 8'(v + 1), 8'(u_cpu.n_vec));
        chk("light released", 8'h00, {5'h0, power_state[1:0], hold_state});
        irq_req = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        u_cpu.exec_op(1'b1, 1'b0);
        chk("light again", 8'h01, {5'h0, power_state});
        t_reset();
    endtask

    task automatic t_deep();
        int n;
        int v;
        int r;
        for (int x = 0; x < 2; x++) begin
            on_xtal = 1'(x);
            u_cpu.irq_disable = 1'(x);
            sys_reg = 8'h04;
            u_cpu.exec_op(1'b1, 1'b0);
            chk("deep state", 8'h03, {5'h0, power_state});
            chk("deep gates", {2'h0, 3'b000, 1'(x), 1'(x), 1'b1},
                {2'h0, osc_fast_en, cpu_clk_en, periph_fast_en, periph_xtal_en, osc_xtal_en, hold_state});
            v = u_cpu.n_vec;
            r = u_cpu.n_res;
            irq_req = 1'b1;
            for (int i = 0; i < 8 && power_state !== 3'h2; i++) begin
                @(posedge clk);
                #1;
            end
            chk("warm state", 8'h12, {3'h0, osc_fast_en, cpu_clk_en, power_state});
            count_gated(n);
            chk("deep warm length", 8'h01, 8'(n >= W - 2 && n <= W + 2));
            repeat (2) @(posedge clk);
            #1;
            chk("deep vector", 8'(v + 1 - x), 8'(u_cpu.n_vec));
            chk("deep resume", 8'(r + x), 8'(u_cpu.n_res));
            irq_req = 1'b0;
            repeat (6) @(posedge clk);
            #1;
        end
    endtask

    task automatic t_stop();
        sys_reg = 8'h00;
        on_xtal = 1'b1;
        u_cpu.exec_op(1'b1, 1'b1);
        chk("stop state", 8'h06, {5'h0, power_state});
        chk("stop gates", 8'h07, {2'h0, osc_fast_en, cpu_clk_en, periph_fast_en, periph_xtal_en,
            osc_xtal_en, hold_state});
        irq_req = 1'b1;
        repeat (40) @(posedge clk);
        #1;
        chk("stop ignores irq", 8'h06, {4'h0, cpu_clk_en, power_state});
        irq_req = 1'b0;
        t_reset();
    endtask

    // watchdog sized well beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        t_reset();
        t_light();
        t_deep();
        t_stop();
        complete_run();
    end
endmodule // test_power_down_mode_control
